// ---- src/hrl_loader.v ----
// hrl_loader.v: parses typed, slash and semicolon records into buffer writes
// assumes characters arrive one per strobe, synchronous to i_clk
`timescale 1ns/10ps
`include "hrl_defines.vh"
module hrl_loader (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_rx_valid,
  input wire [7:0] i_rx_char,
  input wire i_nibble_mode,
  input wire i_ack_ready,
  output reg o_ack_valid,
  output reg [7:0] o_ack_char,
  output reg o_mem_we,
  output reg [31:0] o_mem_addr,
  output reg [7:0] o_mem_data,
  input wire i_mem_ready,
  output reg o_rx_ready,
  output reg o_cksum_err,
  output reg o_abort,
  output reg o_eof,
  output reg o_header,
  output reg [31:0] o_info,
  output reg o_info_valid,
  input wire i_tx_valid,
  input wire [7:0] i_tx_byte,
  output reg o_tx_ready,
  output reg o_tx_char_valid,
  output reg [7:0] o_tx_char,
  input wire i_tx_char_ready
);
  localparam ST_IDLE = 3'h0;
  localparam ST_TYPE = 3'h1;
  localparam ST_LEN = 3'h2;
  localparam ST_ADDR = 3'h3;
  localparam ST_CK1 = 3'h4;
  localparam ST_DATA = 3'h5;
  localparam ST_CK2 = 3'h6;
  localparam ST_EOL = 3'h7;
  reg [2:0] st_r;
  reg [1:0] fmt_r;
  reg [3:0] rtype_r;
  reg [3:0] cnt_r;
  reg [7:0] len_r;
  reg [7:0] left_r;
  reg [31:0] addr_r;
  reg [7:0] pair_r;
  reg hi_r;
  reg [7:0] sum_r;
  reg [7:0] nsum_r;
  reg [7:0] ck_r;
  reg bad_r;
  reg first_r;
  wire buf_ready;
  wire buf_valid;
  wire [39:0] buf_data;
  reg push_r;
  reg [39:0] push_data_r;
  wire enc_ready;
  wire enc_tv;
  wire [7:0] enc_tc;
  reg txh_v_r;
  reg [7:0] txh_r;
  // output stages move on only when empty or taken, so a stalled sink loses nothing
  wire mem_slot_ready = !o_mem_we || i_mem_ready;
  wire enc_slot_ready = !o_tx_char_valid || i_tx_char_ready;
  // mirrors the encoder's accept branch: idle and its own char not stuck
  wire enc_take = txh_v_r && enc_ready && !(enc_tv && !enc_slot_ready);
  function is_hex;
    input [7:0] c;
    begin
      is_hex = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
    end
  endfunction
  function [3:0] hex_val;
    input [7:0] c;
    begin
      hex_val = (c <= 8'h39) ? c[3:0] : (c[3:0] + 4'h9);
    end
  endfunction
  function [3:0] addr_digits;
    input [3:0] t;
    begin
      case (t)
        4'h2, 4'h8: addr_digits = 4'h6; // see RULE_02
        4'h3, 4'h7: addr_digits = 4'h8;
        default: addr_digits = 4'h4;
      endcase
    end
  endfunction
  wire [3:0] nv = hex_val(i_rx_char);
  wire hx = is_hex(i_rx_char);
  wire [7:0] byte_now = {pair_r[3:0], nv};
  wire take = i_rx_valid && o_rx_ready;
  // data typed 1-3 or any semicolon/slash record with length carries memory writes
  wire data_rec = (fmt_r != `HRL_FMT_TYPED) ||
                  (rtype_r >= 4'h1 && rtype_r <= 4'h3); // see RULE_23
  hrl_buf2 u_buf (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_valid(push_r),
    .i_data(push_data_r),
    .o_ready(buf_ready),
    .o_valid(buf_valid),
    .o_data(buf_data),
    .i_ready(mem_slot_ready)
  );
  hrl_hexenc u_enc (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_valid(txh_v_r),
    .i_byte(txh_r),
    .i_nibble_mode(i_nibble_mode),
    .o_ready(enc_ready),
    .o_tx_valid(enc_tv),
    .o_tx_char(enc_tc),
    .i_tx_ready(enc_slot_ready)
  );
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_mem_we <= 1'b0;
      o_mem_addr <= 32'h0;
      o_mem_data <= 8'h00;
      o_tx_ready <= 1'b0;
      o_tx_char_valid <= 1'b0;
      o_tx_char <= 8'h00;
      txh_v_r <= 1'b0;
      txh_r <= 8'h00;
    end else begin
      if (mem_slot_ready) begin
        o_mem_we <= buf_valid;
        o_mem_addr <= buf_data[39:8];
        o_mem_data <= buf_data[7:0];
      end
      if (enc_slot_ready) begin
        o_tx_char_valid <= enc_tv;
        o_tx_char <= enc_tc;
      end
      if (enc_take) begin
        txh_v_r <= 1'b0;
      end
      if (i_tx_valid && o_tx_ready) begin
        txh_v_r <= 1'b1;
        txh_r <= i_tx_byte;
      end
      // registered ready: high only while the one-byte holder is free
      o_tx_ready <= !((txh_v_r && !enc_take) || (i_tx_valid && o_tx_ready));
    end
  end
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= ST_IDLE;
      fmt_r <= `HRL_FMT_TYPED;
      rtype_r <= 4'h0;
      cnt_r <= 4'h0;
      len_r <= 8'h00;
      left_r <= 8'h00;
      addr_r <= 32'h0;
      pair_r <= 8'h00;
      hi_r <= 1'b1;
      sum_r <= 8'h00;
      nsum_r <= 8'h00;
      ck_r <= 8'h00;
      bad_r <= 1'b0;
      first_r <= 1'b0;
      push_r <= 1'b0;
      push_data_r <= 40'h0;
      o_rx_ready <= 1'b1;
      o_ack_valid <= 1'b0;
      o_ack_char <= 8'h00;
      o_cksum_err <= 1'b0;
      o_abort <= 1'b0;
      o_eof <= 1'b0;
      o_header <= 1'b0;
      o_info <= 32'h0;
      o_info_valid <= 1'b0;
    end else begin
      o_cksum_err <= 1'b0;
      o_abort <= 1'b0;
      o_eof <= 1'b0;
      o_header <= 1'b0;
      o_info_valid <= 1'b0;
      if (push_r && buf_ready) begin
        push_r <= 1'b0;
      end
      // stall the line while a byte waits or an acknowledge is unsent
      o_rx_ready <= !(push_r && !buf_ready) && !(o_ack_valid && !i_ack_ready);
      if (o_ack_valid && i_ack_ready) begin
        o_ack_valid <= 1'b0;
      end
      if (take) begin
        if (hx && !hi_r) begin
          pair_r <= byte_now;
        end else if (hx) begin
          pair_r <= {4'h0, nv};
        end
        if (hx) begin
          hi_r <= ~hi_r; // see RULE_06
        end
        case (st_r)
          ST_IDLE: begin
            hi_r <= 1'b1;
            sum_r <= 8'h00;
            nsum_r <= 8'h00;
            bad_r <= 1'b0;
            cnt_r <= 4'h0;
            addr_r <= 32'h0;
            first_r <= 1'b0;
            if (i_rx_char == `HRL_CH_S) begin
              fmt_r <= `HRL_FMT_TYPED;
              st_r <= ST_TYPE; // see RULE_01
            end else if (i_rx_char == `HRL_CH_SLASH) begin
              fmt_r <= `HRL_FMT_SLASH;
              first_r <= 1'b1;
              st_r <= ST_ADDR; // see RULE_14
            end else if (i_rx_char == `HRL_CH_SEMI) begin
              fmt_r <= `HRL_FMT_SEMI;
              st_r <= ST_LEN; // see RULE_20
            end
          end
          ST_TYPE: begin
            rtype_r <= i_rx_char[3:0];
            hi_r <= 1'b1;
            st_r <= (i_rx_char >= 8'h30 && i_rx_char <= 8'h39) ? ST_LEN : ST_IDLE;
          end
          ST_LEN: begin
            if (!hx) begin
              bad_r <= 1'b1;
            end else if (!hi_r) begin
              len_r <= byte_now;
              sum_r <= sum_r + byte_now;
              if (fmt_r == `HRL_FMT_SLASH) begin
                nsum_r <= nsum_r + {4'h0, nv};
                st_r <= ST_CK1; // see RULE_15
              end else begin
                st_r <= ST_ADDR; // see RULE_21
              end
              cnt_r <= 4'h0;
              left_r <= byte_now;
            end else if (fmt_r == `HRL_FMT_SLASH) begin
              nsum_r <= nsum_r + {4'h0, nv};
            end
          end
          ST_ADDR: begin
            if (first_r && i_rx_char == `HRL_CH_SLASH) begin
              o_abort <= 1'b1; // see RULE_19
              st_r <= ST_IDLE;
            end else begin
              first_r <= 1'b0;
              addr_r <= {addr_r[27:0], nv}; // see RULE_07
              if (!hi_r) begin
                sum_r <= sum_r + byte_now;
              end
              nsum_r <= nsum_r + {4'h0, nv};
              cnt_r <= cnt_r + 4'h1;
              if (cnt_r + 4'h1 == ((fmt_r == `HRL_FMT_TYPED) ? addr_digits(rtype_r) : 4'h4))
              begin
                if (fmt_r == `HRL_FMT_SLASH) begin
                  st_r <= ST_LEN;
                end else if (fmt_r == `HRL_FMT_TYPED && (rtype_r == 4'h5 ||
                         rtype_r >= 4'h7)) begin
                  st_r <= ST_CK2; // see RULE_03
                end else begin
                  st_r <= (left_r == 8'h00) ? ST_CK2 : ST_DATA; // see RULE_22
                end
                // typed length counts address and checksum bytes
                if (fmt_r == `HRL_FMT_TYPED) begin
                  left_r <= len_r - {4'h0, addr_digits(rtype_r) >> 1} - 8'h01;
                  if (len_r == {4'h0, addr_digits(rtype_r) >> 1} + 8'h01) begin
                    st_r <= ST_CK2;
                  end
                end
              end
            end
          end
          ST_CK1: begin
            if (!hi_r) begin
              if (byte_now != nsum_r) begin
                bad_r <= 1'b1; // see RULE_16
              end
              nsum_r <= 8'h00;
              st_r <= (len_r == 8'h00) ? ST_EOL : ST_DATA;
              left_r <= len_r;
            end
          end
          ST_DATA: begin
            nsum_r <= nsum_r + {4'h0, nv};
            if (!hi_r) begin
              sum_r <= sum_r + byte_now;
              push_r <= data_rec; // see RULE_23
              push_data_r <= {addr_r, (i_nibble_mode ? {4'h0, nv} : byte_now)}; // see RULE_09
              addr_r <= addr_r + 32'h1;
              left_r <= left_r - 8'h01;
              if (left_r == 8'h01) begin
                st_r <= ST_CK2;
              end
            end
          end
          ST_CK2: begin
            if (!hi_r) begin
              ck_r <= byte_now;
              st_r <= ST_EOL;
              if (fmt_r == `HRL_FMT_TYPED) begin
                if (sum_r + byte_now != `HRL_SUM_GOOD) begin // see RULE_11
                  o_cksum_err <= 1'b1; // see RULE_12
                end
                if (rtype_r == 4'h0) begin
                  o_header <= 1'b1; // see RULE_05
                end else if (rtype_r == 4'h5 || rtype_r >= 4'h7) begin
                  o_info <= addr_r; // see RULE_08
                  o_info_valid <= 1'b1;
                  o_eof <= (rtype_r >= 4'h7); // see RULE_04
                end
              end else if (fmt_r == `HRL_FMT_SLASH) begin
                if (byte_now != nsum_r) begin
                  bad_r <= 1'b1; // see RULE_17
                end
              end else begin
                st_r <= ST_EOL;
              end
            end
          end
          ST_EOL: begin
            // typed data with checksum flagged on pair; semicolon tail skipped
            if (fmt_r == `HRL_FMT_TYPED && sum_r + ck_r != `HRL_SUM_GOOD) begin
              bad_r <= 1'b1; // see RULE_12
            end
            // a bare carriage return is only waited through
            if (i_rx_char == `HRL_CH_LF) begin
              st_r <= ST_IDLE;
              if (fmt_r == `HRL_FMT_SLASH) begin
                o_ack_valid <= 1'b1; // see RULE_18
                o_ack_char <= bad_r ? `HRL_CH_SEVEN : `HRL_CH_ZERO; // see RULE_13
                if (!bad_r && len_r == 8'h00) begin
                  o_eof <= 1'b1;
                end
              end else if (fmt_r == `HRL_FMT_SEMI && len_r == 8'h00) begin
                o_eof <= 1'b1;
              end
            end else if (i_rx_char == `HRL_CH_S || i_rx_char == `HRL_CH_SEMI) begin
              st_r <= ST_IDLE;
            end
          end
          default: begin
            st_r <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// ---- src/hrl_defines.vh ----
// hrl_defines.vh: constants of the record loader and record sender
// assumes plain verilog-2005 includers; definitions only
//
// Functional notes
// RULE_01: typed record opens with S then type digit
// RULE_02: types 1,2,3 carry 2,3,4-byte load address
// RULE_03: type 5 address field is record count
// RULE_04: types 7,8,9 terminate block, no data
// RULE_05: type 0 headers accepted, several allowed
// RULE_06: length is two hex digits, high first
// RULE_07: address high digit first, bytes to successive addresses
// RULE_08: end record address zeros or start address
// RULE_09: data pairs high first; 4-bit uses low digit
// RULE_10: 4-bit data sent with high digit F
// RULE_11: byte sum including checksum equals FF
// RULE_12: failed typed checksum reports checksum error
// RULE_13: slash line answered 0 good, 7 bad
// RULE_14: slash record: slash then four address digits
// RULE_15: slash length two digits, send max 16, zero ends
// RULE_16: first slash sum is address/length nibbles
// RULE_17: second slash sum is data nibbles mod 256
// RULE_18: slash record ends CR LF, then acknowledge
// RULE_19: double slash line aborts transfer
// RULE_20: semicolon record opens with semicolon
// RULE_21: semicolon length two digits, zero ends
// RULE_22: semicolon address four digits, successive bytes
// RULE_23: header, count, end records write no memory
`ifndef HRL_DEFINES_VH
`define HRL_DEFINES_VH
`define HRL_CH_S 8'h53
`define HRL_CH_SLASH 8'h2F
`define HRL_CH_SEMI 8'h3B
`define HRL_CH_CR 8'h0D
`define HRL_CH_LF 8'h0A
`define HRL_CH_ZERO 8'h30
`define HRL_CH_SEVEN 8'h37
`define HRL_CH_F 8'h46
`define HRL_FMT_TYPED 2'h0
`define HRL_FMT_SLASH 2'h1
`define HRL_FMT_SEMI 2'h2
`define HRL_SUM_GOOD 8'hFF
`define HRL_SLASH_MAX 8'h10
`endif

// ---- src/hrl_buf2.v ----
// hrl_buf2.v: two-entry buffer with valid/ready on both sides
// assumes one clock, asynchronous active-low reset
`timescale 1ns/10ps
module hrl_buf2 (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_valid,
  input wire [39:0] i_data,
  output wire o_ready,
  output wire o_valid,
  output wire [39:0] o_data,
  input wire i_ready
);
  reg [39:0] mem_r [0:1];
  reg rd_r;
  reg wr_r;
  reg [1:0] cnt_r;
  wire push = i_valid && (cnt_r != 2'h2);
  wire pop = i_ready && (cnt_r != 2'h0);
  assign o_ready = (cnt_r != 2'h2);
  assign o_valid = (cnt_r != 2'h0);
  assign o_data = mem_r[rd_r];
  always @(posedge i_clk) begin
    if (push) begin
      mem_r[wr_r] <= i_data;
    end
  end
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) begin
        wr_r <= ~wr_r;
      end
      if (pop) begin
        rd_r <= ~rd_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ---- src/hrl_hexenc.v ----
// hrl_hexenc.v: sends typed data bytes as ASCII pairs
// assumes the sink may stall; one character per accepted cycle
`timescale 1ns/10ps
`include "hrl_defines.vh"
module hrl_hexenc (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_valid,
  input wire [7:0] i_byte,
  input wire i_nibble_mode,
  output reg o_ready,
  output reg o_tx_valid,
  output reg [7:0] o_tx_char,
  input wire i_tx_ready
);
  reg [7:0] byte_r;
  reg phase_r;
  function [7:0] to_hex;
    input [3:0] n;
    begin
      to_hex = (n < 4'hA) ? {4'h3, n} : (8'h37 + {4'h0, n});
    end
  endfunction
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      byte_r <= 8'h00;
      phase_r <= 1'b0;
      o_ready <= 1'b1;
      o_tx_valid <= 1'b0;
      o_tx_char <= 8'h00;
    end else if (o_tx_valid && !i_tx_ready) begin
      o_tx_valid <= 1'b1;
    end else if (phase_r) begin
      o_tx_valid <= 1'b1;
      o_tx_char <= to_hex(byte_r[3:0]);
      phase_r <= 1'b0;
      o_ready <= 1'b1;
    end else if (o_ready && i_valid) begin
      byte_r <= i_byte;
      o_tx_valid <= 1'b1;
      o_tx_char <= i_nibble_mode ? `HRL_CH_F : to_hex(i_byte[7:4]); // see RULE_10
      phase_r <= 1'b1;
      o_ready <= 1'b0;
    end else begin
      o_tx_valid <= 1'b0;
    end
  end
endmodule

// ---- test/hrl_loader_properties.sv ----
// hrl_loader_properties.sv: port assertions for the record loader
// assumes one clock domain and async active-low reset
`timescale 1ns/10ps
module hrl_loader_properties (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_nibble_mode,
  input wire i_ack_ready,
  input wire o_ack_valid,
  input wire [7:0] o_ack_char,
  input wire o_mem_we,
  input wire [31:0] o_mem_addr,
  input wire [7:0] o_mem_data,
  input wire i_mem_ready,
  input wire o_cksum_err,
  input wire o_abort,
  input wire o_tx_char_valid,
  input wire [7:0] o_tx_char,
  input wire i_tx_char_ready
);
  reg hi_r;
  // even count of sent chars: high digit due next
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hi_r <= 1'b1;
    end else if (o_tx_char_valid && i_tx_char_ready) begin
      hi_r <= ~hi_r;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  chk_ack_code: assert property (
    o_ack_valid |-> o_ack_char inside {8'h30, 8'h37})
    else $error("ack char not 0 or 7");
  chk_ack_hold: assert property (
    o_ack_valid && !i_ack_ready |=> o_ack_valid && $stable(o_ack_char))
    else $error("ack dropped before taken");
  chk_tx_hold: assert property (
    o_tx_char_valid && !i_tx_char_ready |=> o_tx_char_valid && $stable(o_tx_char))
    else $error("sent char dropped before taken");
  chk_tx_hex: assert property (
    o_tx_char_valid |-> o_tx_char inside {[8'h30:8'h39], [8'h41:8'h46]})
    else $error("sent char not hex digit");
  chk_nib_high: assert property (
    o_tx_char_valid && hi_r && i_nibble_mode |-> o_tx_char == 8'h46)
    else $error("4-bit high digit not F");
  chk_mem_hold: assert property (
    o_mem_we && !i_mem_ready |=> o_mem_we && $stable(o_mem_addr) && $stable(o_mem_data))
    else $error("stalled write changed");
  chk_mem_nib: assert property (
    o_mem_we && i_nibble_mode |-> o_mem_data[7:4] == 4'h0)
    else $error("4-bit write has high bits");
  chk_err_pulse: assert property (
    o_cksum_err |=> !o_cksum_err)
    else $error("checksum error longer than a cycle");
  chk_abort_pulse: assert property (
    $rose(o_abort) |=> $fell(o_abort))
    else $error("abort longer than a cycle");
  cover property (o_ack_valid && o_ack_char == 8'h37);
  cover property (o_mem_we && !i_mem_ready);
  cover property (o_cksum_err);
endmodule
bind hrl_loader hrl_loader_properties chk_u (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_nibble_mode(i_nibble_mode), .i_ack_ready(i_ack_ready), .o_ack_valid(o_ack_valid),
  .o_ack_char(o_ack_char), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
  .o_mem_data(o_mem_data), .i_mem_ready(i_mem_ready), .o_cksum_err(o_cksum_err),
  .o_abort(o_abort), .o_tx_char_valid(o_tx_char_valid), .o_tx_char(o_tx_char),
  .i_tx_char_ready(i_tx_char_ready));

// ---- test/hrl_host_model.sv ----
// hrl_host_model.sv: far-side host sending records, taking acks, memory and chars
// assumes send is called just after a rising edge of i_clk
`timescale 1ns/10ps
module hrl_host_model (
  input wire i_clk,
  input wire i_rx_ready,
  output reg o_rx_valid,
  output reg [7:0] o_rx_char,
  input wire i_ack_valid,
  input wire [7:0] i_ack_char,
  output reg o_ack_ready,
  input wire i_mem_we,
  input wire [31:0] i_mem_addr,
  input wire [7:0] i_mem_data,
  output reg o_mem_ready,
  input wire i_tx_char_valid,
  input wire [7:0] i_tx_char,
  output reg o_tx_char_ready
);
  reg [31:0] wa_q[$];
  reg [7:0] wd_q[$];
  reg [7:0] ack_q[$];
  reg [7:0] tx_q[$];
  reg mem_stall = 1'b0;
  int ack_wait = 0;
  int ack_cnt = 0;
  reg [1:0] tx_cnt = 2'h0;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_char = 8'hFF;
    o_ack_ready = 1'b0;
    o_mem_ready = 1'b1;
    o_tx_char_ready = 1'b0;
  end
  always @(posedge i_clk) begin
    if (i_mem_we && o_mem_ready) begin
      wa_q.push_back(i_mem_addr);
      wd_q.push_back(i_mem_data);
    end
    if (i_ack_valid && o_ack_ready) ack_q.push_back(i_ack_char);
    if (i_tx_char_valid && o_tx_char_ready) tx_q.push_back(i_tx_char);
    o_mem_ready <= !mem_stall;
    // slow ack taker, so a held ack is really exercised
    ack_cnt <= i_ack_valid ? ack_cnt + 1 : 0;
    o_ack_ready <= i_ack_valid && !o_ack_ready && ack_cnt >= ack_wait;
    tx_cnt <= tx_cnt + 2'h1;
    o_tx_char_ready <= tx_cnt[1];
  end
  // chars of a whole record, held until taken
  task automatic send(input string s);
    int i;
    for (i = 0; i < s.len(); i++) begin
      o_rx_valid <= 1'b1;
      o_rx_char <= s[i];
      @(posedge i_clk);
      while (!i_rx_ready) @(posedge i_clk);
    end
    o_rx_valid <= 1'b0;
    o_rx_char <= ~s[s.len() - 1];
  endtask
endmodule

// ---- test/hrl_loader_tb.sv ----
// hrl_loader_tb.sv: self-checking bench for the record loader
// assumes hrl_host_model on the far side and the bound checker
`timescale 1ns/10ps
module hrl_loader_tb;
  reg i_clk = 1'b0;
  reg i_reset_n = 1'b0;
  reg i_nibble_mode = 1'b0;
  reg i_tx_valid = 1'b0;
  reg [7:0] i_tx_byte = 8'h00;
  wire rx_valid, ack_ready, mem_ready, tcr, rx_ready, ack_valid, mem_we, tx_ready, tcv;
  wire [7:0] rx_char, ack_char, mem_data, tx_char;
  wire [31:0] mem_addr, info;
  wire cksum_err, abort, eof, header, info_valid;
  int n_mismatch = 0;
  int checked = 0;
  int n_err = 0, n_eof = 0, n_hdr = 0, n_abort = 0, n_info = 0, n_stall = 0;
  reg [31:0] last_info = 32'h0;
  always #5 i_clk = ~i_clk;
  hrl_loader dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_rx_valid(rx_valid),
    .i_rx_char(rx_char), .i_nibble_mode(i_nibble_mode), .i_ack_ready(ack_ready),
    .o_ack_valid(ack_valid), .o_ack_char(ack_char), .o_mem_we(mem_we),
    .o_mem_addr(mem_addr), .o_mem_data(mem_data), .i_mem_ready(mem_ready),
    .o_rx_ready(rx_ready), .o_cksum_err(cksum_err), .o_abort(abort), .o_eof(eof),
    .o_header(header), .o_info(info), .o_info_valid(info_valid), .i_tx_valid(i_tx_valid),
    .i_tx_byte(i_tx_byte), .o_tx_ready(tx_ready), .o_tx_char_valid(tcv),
    .o_tx_char(tx_char), .i_tx_char_ready(tcr));
  hrl_host_model host_u (.i_clk(i_clk), .i_rx_ready(rx_ready), .o_rx_valid(rx_valid),
    .o_rx_char(rx_char), .i_ack_valid(ack_valid), .i_ack_char(ack_char),
    .o_ack_ready(ack_ready), .i_mem_we(mem_we), .i_mem_addr(mem_addr),
    .i_mem_data(mem_data), .o_mem_ready(mem_ready), .i_tx_char_valid(tcv),
    .i_tx_char(tx_char), .o_tx_char_ready(tcr));
  always @(posedge i_clk) begin
    n_err += (cksum_err === 1'b1);
    n_eof += (eof === 1'b1);
    n_hdr += (header === 1'b1);
    n_abort += (abort === 1'b1);
    n_stall += (rx_ready === 1'b0);
    if (info_valid === 1'b1) begin
      n_info++;
      last_info <= info;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rec(input string s);
    @(posedge i_clk);
    host_u.send({s, "\015\012"});
    // answers come a few cycles after the line end
    repeat (12) @(posedge i_clk);
  endtask
  task wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] ga;
    logic [7:0] gd;
    ga = 32'hX;
    gd = 8'hX;
    if (host_u.wa_q.size() != 0) begin
      ga = host_u.wa_q.pop_front();
      gd = host_u.wd_q.pop_front();
    end
    chk(ga, a);
    chk({24'h0, gd}, {24'h0, d});
  endtask
  task drop;
    host_u.wa_q.delete();
    host_u.wd_q.delete();
  endtask
  task tx(input logic [7:0] b, input logic [7:0] hi, input logic [7:0] lo);
    int k;
    @(posedge i_clk);
    i_tx_valid <= 1'b1;
    i_tx_byte <= b;
    @(posedge i_clk);
    for (k = 0; k < 50 && !tx_ready; k++) @(posedge i_clk);
    i_tx_valid <= 1'b0;
    i_tx_byte <= ~b;
    for (k = 0; k < 50 && host_u.tx_q.size() < 2; k++) @(posedge i_clk);
    chk({24'h0, host_u.tx_q.pop_front()}, {24'h0, hi});
    chk({24'h0, host_u.tx_q.pop_front()}, {24'h0, lo});
  endtask
  task t_hdr;
    rec("S00600004844521B");
    rec("S00600004844521B");
    chk(n_hdr, 2);
    chk(host_u.wa_q.size(), 0);
  endtask
  task t_data;
    host_u.mem_stall = 1'b1;
    fork
      begin
        repeat (40) @(posedge i_clk);
        host_u.mem_stall = 1'b0;
      end
    join_none
    rec("S107003000144ED492");
    wr(32'h30, 8'h00);
    wr(32'h31, 8'h14);
    wr(32'h32, 8'h4E);
    wr(32'h33, 8'hD4);
    chk(n_stall != 0, 1);
    rec("S2050C2905754B");
    wr(32'h000C2905, 8'h75);
    rec("S306995112345673");
    wr(32'h99511234, 8'h56);
    chk(n_err, 0);
  endtask
  task t_term;
    string r[4];
    logic [31:0] v[4];
    int i;
    r = '{"S5030004F8", "S804000100FA", "S70500001000EA", "S9031234B6"};
    v = '{32'h4, 32'h100, 32'h1000, 32'h1234};
    for (i = 0; i < 4; i++) begin
      rec(r[i]);
      chk(n_info, i + 1);
      chk(last_info, v[i]);
    end
    chk(n_eof, 3);
    chk(host_u.wa_q.size(), 0);
  endtask
  task t_misc;
    int i;
    rec("S107003000144ED493");
    chk(n_err, 1);
    drop;
    i_nibble_mode <= 1'b1;
    rec("S1041000A546");
    wr(32'h1000, 8'h05);
    tx(8'h05, 8'h46, 8'h35);
    i_nibble_mode <= 1'b0;
    tx(8'h3C, 8'h33, 8'h43);
    rec(";010020AB00CC");
    wr(32'h20, 8'hAB);
    host_u.ack_wait = 3;
    rec("/000005051A023F7B633A");
    chk({24'h0, host_u.ack_q.pop_front()}, 32'h30);
    for (i = 0; i < 5; i++) wr(i, 40'h1A023F7B63 >> (8 * (4 - i)));
    rec("/000005051A023F7B633B");
    chk({24'h0, host_u.ack_q.pop_front()}, 32'h37);
    rec("//00");
    chk(n_abort, 1);
  endtask
  task conclude;
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    t_hdr;
    t_data;
    t_term;
    t_misc;
    conclude;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    $display("BAD %0t: watchdog expired", $time);
    conclude;
  end
endmodule
